/* File: src/lane_shifter.sv */
`timescale 1ns/1ps
module lane_shifter #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // control
    input wire logic load,
    input wire logic shift,
    input wire logic [W-1:0] load_data,
    // differential lane
    output logic lane_pos_ff,
    output logic lane_neg_ff
);
    logic [W-1:0] shreg_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shreg_ff <= '0;
            lane_pos_ff <= 1'b0;
            lane_neg_ff <= 1'b1;
        end else if (load) begin
            shreg_ff <= load_data >> 1;
            lane_pos_ff <= load_data[0];
            lane_neg_ff <= ~load_data[0];
        end else if (shift) begin
            shreg_ff <= shreg_ff >> 1;
            lane_pos_ff <= shreg_ff[0];
            lane_neg_ff <= ~shreg_ff[0];
        end
    end
endmodule

/* File: src/quad_adc_lvds_serializer.sv */
`timescale 1ns/1ps
module quad_adc_lvds_serializer
    import serdes_pkg::*;
#(
    parameter int NCH = serdes_pkg::CHANNELS,
    parameter int DEPTH = serdes_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // converted samples, one word per channel
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [NCH*serdes_pkg::WORD_BITS-1:0] sample_data,
    // configuration
    input wire serdes_pkg::out_fmt_e format_sel,
    input wire serdes_pkg::div_mode_e div_sel,
    input wire logic sync_buffer_powerdown,
    // sync reference receiver
    input wire logic sync_reference_pos,
    input wire logic sync_reference_neg,
    // data lanes
    output logic [NCH-1:0] upper_lane_pos,
    output logic [NCH-1:0] upper_lane_neg,
    output logic [NCH-1:0] lower_lane_pos,
    output logic [NCH-1:0] lower_lane_neg,
    // clocks to the receiver
    output logic bit_clk_pos_ff,
    output logic bit_clk_neg_ff,
    output logic frame_clk_pos_ff,
    output logic frame_clk_neg_ff,
    output logic div_clk_ff,
    // status
    output logic underrun_ff,
    output serdes_pkg::out_fmt_e format_ff
);
    import serdes_pkg::*;

    localparam int WW = NCH * WORD_BITS;

    word_stream_if #(.W(WW)) head ();

    div_mode_e div_mode_ff;
    logic [1:0] div_cnt_ff;
    logic [1:0] nxt_div_cnt;
    logic [1:0] cur_div_last;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [3:0] cur_last;
    logic [3:0] frame_hi;
    logic sync_in;
    logic sync_d_ff;
    logic sync_rise;
    logic step;
    logic frame_end;
    logic load_one_wire;
    logic [WW-1:0] load_word;

    sample_fifo #(.W(WW), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out(head.src)
    );

    // sync receiver; powered-down buffer reads as a steady low
    assign sync_in = sync_reference_pos && !sync_reference_neg &&
        !sync_buffer_powerdown;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_d_ff <= 1'b0;
        end else begin
            sync_d_ff <= sync_in;
        end
    end

    // every rising edge realigns, so one-shot and periodic both work
    assign sync_rise = sync_in && !sync_d_ff;

    // input clock divider; one step is one bit clock edge
    assign cur_div_last = div_last(div_mode_ff);
    assign step = (div_cnt_ff == cur_div_last);

    always_comb begin
        if (sync_rise) begin
            nxt_div_cnt = DIV_CNT_RST;
        end else if (step) begin
            nxt_div_cnt = DIV_CNT_RST;
        end else begin
            nxt_div_cnt = div_cnt_ff + 2'h1;
        end
    end

    // re-phasing only delays the next step, no bit is dropped
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_ff <= DIV_CNT_RST;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
        end
    end

    // divided clock: falls when the counter wraps to zero; in bypass it toggles every cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_clk_ff <= 1'b0;
        end else if (div_mode_ff == DIV_BYPASS) begin
            div_clk_ff <= ~div_clk_ff;
        end else begin
            div_clk_ff <= (nxt_div_cnt > (cur_div_last >> 1));
        end
    end

    // word position
    assign cur_last = (format_ff == FMT_ONE_WIRE) ? LAST_ONE_WIRE :
        LAST_TWO_WIRE;
    assign frame_end = step && (idx_ff == cur_last);
    assign nxt_idx = frame_end ? 4'h0 : idx_ff + 4'h1;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_ff <= IDX_RST;
        end else if (step) begin
            idx_ff <= nxt_idx;
        end
    end

    // settings only move between words
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            format_ff <= RST_FMT;
            div_mode_ff <= RST_DIV;
        end else if (frame_end) begin
            format_ff <= format_sel;
            div_mode_ff <= div_sel;
        end
    end

    // empty fifo sends a zero word rather than stalling the link
    assign head.ready = frame_end;
    assign load_word = head.valid ? head.data : '0;
    assign load_one_wire = (format_sel == FMT_ONE_WIRE);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            underrun_ff <= 1'b0;
        end else begin
            underrun_ff <= frame_end && !head.valid;
        end
    end

    // frame clock high over the first part of each word
    always_comb begin
        if (frame_end) begin
            frame_hi = load_one_wire ? FRAME_HI_ONE : FRAME_HI_TWO;
        end else begin
            frame_hi = (format_ff == FMT_ONE_WIRE) ? FRAME_HI_ONE :
                FRAME_HI_TWO;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_clk_pos_ff <= 1'b0;
            frame_clk_neg_ff <= 1'b1;
            bit_clk_pos_ff <= 1'b0;
            bit_clk_neg_ff <= 1'b1;
        end else if (step) begin
            frame_clk_pos_ff <= (nxt_idx < frame_hi);
            frame_clk_neg_ff <= !(nxt_idx < frame_hi);
            bit_clk_pos_ff <= ~bit_clk_pos_ff;
            bit_clk_neg_ff <= bit_clk_pos_ff;
        end
    end

    // lanes per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [WORD_BITS-1:0] w;
        logic [WORD_BITS-1:0] lo_data;
        logic [WORD_BITS-1:0] up_data;

        assign w = load_word[c*WORD_BITS +: WORD_BITS];
        // one-wire keeps the upper lane idle low
        assign lo_data = load_one_wire ? w :
            {{HALF_BITS{1'b0}}, w[HALF_BITS-1:0]};
        assign up_data = load_one_wire ? '0 :
            {{HALF_BITS{1'b0}}, w[WORD_BITS-1:HALF_BITS]};

        lane_shifter #(.W(WORD_BITS)) u_lo (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .load(frame_end),
            .shift(step && !frame_end),
            .load_data(lo_data),
            .lane_pos_ff(lower_lane_pos[c]),
            .lane_neg_ff(lower_lane_neg[c])
        );

        lane_shifter #(.W(WORD_BITS)) u_up (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .load(frame_end),
            .shift(step && !frame_end),
            .load_data(up_data),
            .lane_pos_ff(upper_lane_pos[c]),
            .lane_neg_ff(upper_lane_neg[c])
        );
    end

    sequence s_load_one;
        frame_end && load_one_wire;
    endsequence

    sequence s_load_two;
        frame_end && !load_one_wire;
    endsequence

    // checker-only step count, kept apart from idx_ff on purpose
    logic [3:0] chk_steps_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_steps_ff <= IDX_RST;
        end else if (frame_end) begin
            chk_steps_ff <= 4'h0;
        end else if (step) begin
            chk_steps_ff <= chk_steps_ff + 4'h1;
        end
    end

    a_sync_realign: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        sync_rise |=> div_cnt_ff == 2'h0 &&
        (div_mode_ff == DIV_BYPASS || !div_clk_ff))
        else $error("sync edge did not restart divider");

    // a gated-off sync must not disturb the divider count
    a_sync_off: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        sync_buffer_powerdown && !step |=>
        div_cnt_ff == $past(div_cnt_ff) + 2'h1)
        else $error("sync seen while buffer powered down");

    a_bit_edge: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        step |=> bit_clk_pos_ff != $past(bit_clk_pos_ff))
        else $error("bit clock missed an edge");

    a_bit_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !step |=> $stable(bit_clk_pos_ff) && $stable(lower_lane_pos))
        else $error("bit clock or lane moved without a step");

    a_fmt_boundary: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $changed(format_ff) |-> $past(frame_end))
        else $error("format changed inside a word");

    a_div_boundary: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $changed(div_mode_ff) |-> $past(frame_end))
        else $error("divider changed inside a word");

    a_one_wire_lsb: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        s_load_one |=> frame_clk_pos_ff &&
        lower_lane_pos[0] == $past(load_word[0]) && !upper_lane_pos[0])
        else $error("one-wire word did not start lsb at frame rise");

    a_two_wire_split: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        s_load_two |=> upper_lane_pos[0] == $past(load_word[7]) &&
        lower_lane_pos[0] == $past(load_word[0]))
        else $error("two-wire halves on wrong lanes");

    a_bypass_step: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        div_mode_ff == DIV_BYPASS |-> step)
        else $error("bypass divider skipped a step");

    a_word_len: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        frame_end |-> chk_steps_ff == ((format_ff == FMT_ONE_WIRE) ?
        4'(WORD_BITS - 1) : 4'(HALF_BITS - 1)))
        else $error("word length wrong for format");

    a_frame_rise: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(frame_clk_pos_ff) |-> idx_ff == 4'h0)
        else $error("frame clock rose inside a word");

    a_frame_low: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        frame_end |-> !frame_clk_pos_ff)
        else $error("frame clock high at end of word");

    a_lane_diff: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        lower_lane_neg == ~lower_lane_pos &&
        upper_lane_neg == ~upper_lane_pos &&
        bit_clk_neg_ff != bit_clk_pos_ff &&
        frame_clk_neg_ff != frame_clk_pos_ff)
        else $error("differential pair halves not complementary");

    a_ready_full: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !sample_ready |-> head.valid)
        else $error("fifo full while head register empty");
endmodule

/* File: src/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
    parameter int W = 56,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    word_stream_if.src out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] count_ff;
    logic out_valid_ff;
    logic [W-1:0] out_data_ff;
    logic push;
    logic pop;

    // depth must be a power of two: pointers wrap naturally
    assign in_ready = (count_ff != DEPTH_C);
    assign push = in_valid && in_ready;
    assign pop = (count_ff != '0) && (!out_valid_ff || out.ready);
    assign out.valid = out_valid_ff;
    assign out.data = out_data_ff;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // head word held in a register so the drain sees flop data
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (pop) begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem[rptr_ff];
        end else if (out.ready) begin
            out_valid_ff <= 1'b0;
        end
    end

    a_fifo_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
        count_ff <= DEPTH_C)
        else $error("fifo count above depth");
endmodule

/* File: src/serdes_pkg.sv */
package serdes_pkg;
    typedef enum logic [1:0] {DIV_BYPASS, DIV_BY2, DIV_BY4} div_mode_e;
    typedef enum logic {FMT_TWO_WIRE, FMT_ONE_WIRE} out_fmt_e;

    localparam int CHANNELS = 4;
    localparam int WORD_BITS = 14;
    localparam int HALF_BITS = 7;
    localparam int FIFO_DEPTH = 8;

    localparam out_fmt_e RST_FMT = FMT_TWO_WIRE;
    localparam div_mode_e RST_DIV = DIV_BYPASS;
    localparam logic [1:0] DIV_CNT_RST = 2'h0;
    localparam logic [3:0] LAST_ONE_WIRE = 4'hd;
    localparam logic [3:0] LAST_TWO_WIRE = 4'h6;
    localparam logic [3:0] IDX_RST = LAST_TWO_WIRE;
    localparam logic [3:0] FRAME_HI_ONE = 4'h7;
    localparam logic [3:0] FRAME_HI_TWO = 4'h4;
    localparam logic [1:0] DIV_LAST_BYPASS = 2'h0;
    localparam logic [1:0] DIV_LAST_BY2 = 2'h1;
    localparam logic [1:0] DIV_LAST_BY4 = 2'h3;

    function automatic logic [1:0] div_last(input div_mode_e m);
        case (m)
            DIV_BY2: div_last = DIV_LAST_BY2;
            DIV_BY4: div_last = DIV_LAST_BY4;
            default: div_last = DIV_LAST_BYPASS;
        endcase
    endfunction
endpackage

/* File: src/word_stream_if.sv */
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 56);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: tb/lane_rx_model.sv */
`timescale 1ns/1ps
module lane_rx_model
    import serdes_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // lanes and clocks from the block
    input wire logic [3:0] up_p,
    input wire logic [3:0] up_n,
    input wire logic [3:0] lo_p,
    input wire logic [3:0] lo_n,
    input wire logic bclk_p,
    input wire logic bclk_n,
    input wire logic fclk_p,
    input wire logic fclk_n,
    input wire serdes_pkg::out_fmt_e fmt,
    // recovered words
    output logic rx_valid,
    output logic [55:0] rx_word,
    output int err_cnt
);
    logic bclk_q = 1'b0;
    logic fclk_q = 1'b0;
    logic [55:0] acc = '0;
    logic [3:0] idx = 4'hf;
    logic [3:0] lastq = 4'hf;
    logic [3:0] hi;
    initial begin
        rx_valid = 1'b0;
        rx_word = '0;
        err_cnt = 0;
    end
    // sampled mid-cycle, away from the edge where the lanes move
    always @(negedge sys_clk) begin
        rx_valid = 1'b0;
        if ((up_n !== ~up_p) || (lo_n !== ~lo_p) || (bclk_n !== ~bclk_p) ||
            (fclk_n !== ~fclk_p))
            err_cnt = err_cnt + 1;
        if (bclk_p !== bclk_q) begin
            bclk_q = bclk_p;
            hi = (fmt == FMT_ONE_WIRE) ? FRAME_HI_ONE : FRAME_HI_TWO;
            if (fclk_p === 1'b1 && fclk_q === 1'b0) begin
                if (idx != 4'hf && idx != lastq)
                    err_cnt = err_cnt + 1;
                idx = 4'h0;
                lastq = (fmt == FMT_ONE_WIRE) ? LAST_ONE_WIRE : LAST_TWO_WIRE;
            end else if (idx != 4'hf) begin
                idx = idx + 4'h1;
            end
            if (idx != 4'hf) begin
                if (fclk_p !== (idx < hi))
                    err_cnt = err_cnt + 1;
                for (int c = 0; c < 4; c++) begin
                    acc[14 * c + idx] = lo_p[c];
                    if (lastq == LAST_TWO_WIRE)
                        acc[14 * c + 7 + idx] = up_p[c];
                    else if (up_p[c] !== 1'b0)
                        err_cnt = err_cnt + 1;
                end
                if (idx == lastq) begin
                    rx_word = acc;
                    rx_valid = 1'b1;
                end
            end
            fclk_q = fclk_p;
        end
    end
endmodule

/* File: tb/quad_adc_lvds_serializer_tb_top.sv */
`timescale 1ns/1ps
module quad_adc_lvds_serializer_tb_top;
    import serdes_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic sample_ready;
    logic [55:0] sample_data = '0;
    out_fmt_e format_sel = FMT_TWO_WIRE;
    div_mode_e div_sel = DIV_BYPASS;
    logic sync_buffer_powerdown = 1'b0;
    logic sync_reference_pos = 1'b0;
    logic sync_reference_neg = 1'b1;
    logic [3:0] upper_lane_pos, upper_lane_neg, lower_lane_pos, lower_lane_neg;
    logic bit_clk_pos_ff, bit_clk_neg_ff, frame_clk_pos_ff, frame_clk_neg_ff;
    logic div_clk_ff, underrun_ff, rx_valid;
    out_fmt_e format_ff;
    logic [55:0] rx_word;
    int err_cnt;
    int n_fail = 0;
    int num_checks = 0;
    logic [55:0] exp_q[$];

    // full-rate sample clock: two-wire, no low-speed setting needed
    always #2 sys_clk = ~sys_clk;

    quad_adc_lvds_serializer u_quad_adc_lvds_serializer (
        .sys_clk(sys_clk), .arst_n(arst_n), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data),
        .format_sel(format_sel), .div_sel(div_sel),
        .sync_buffer_powerdown(sync_buffer_powerdown),
        .sync_reference_pos(sync_reference_pos),
        .sync_reference_neg(sync_reference_neg),
        .upper_lane_pos(upper_lane_pos), .upper_lane_neg(upper_lane_neg),
        .lower_lane_pos(lower_lane_pos), .lower_lane_neg(lower_lane_neg),
        .bit_clk_pos_ff(bit_clk_pos_ff), .bit_clk_neg_ff(bit_clk_neg_ff),
        .frame_clk_pos_ff(frame_clk_pos_ff),
        .frame_clk_neg_ff(frame_clk_neg_ff), .div_clk_ff(div_clk_ff),
        .underrun_ff(underrun_ff), .format_ff(format_ff));

    lane_rx_model u_lane_rx_model (
        .sys_clk(sys_clk), .up_p(upper_lane_pos), .up_n(upper_lane_neg),
        .lo_p(lower_lane_pos), .lo_n(lower_lane_neg),
        .bclk_p(bit_clk_pos_ff), .bclk_n(bit_clk_neg_ff),
        .fclk_p(frame_clk_pos_ff), .fclk_n(frame_clk_neg_ff),
        .fmt(format_ff), .rx_valid(rx_valid), .rx_word(rx_word),
        .err_cnt(err_cnt));

    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic give_up();
        n_fail++;
        tally_and_finish();
    endtask

    task automatic chk_val(input logic [55:0] got, input logic [55:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [55:0] word(input int k);
        word = 56'h9abcdef0123457 + 56'(k) * 56'h0f3a5c7e9b2d1;
    endfunction

    // zero words are underrun fill, not traffic
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1 && rx_word !== '0) begin
            if (exp_q.size() == 0)
                chk_val(rx_word, '0);
            else
                chk_val(rx_word, exp_q.pop_front());
        end
    end

    task automatic push(input logic [55:0] d);
        sample_valid <= 1'b1;
        sample_data <= d;
        for (int i = 0; i < 400; i++) begin
            @(negedge sys_clk);
            if (sample_ready === 1'b1) begin
                @(posedge sys_clk);
                exp_q.push_back(d);
                return;
            end
        end
        give_up();
    endtask

    task automatic drain();
        for (int i = 0; i < 2000; i++) begin
            if (exp_q.size() == 0)
                return;
            @(posedge sys_clk);
        end
        give_up();
    endtask

    task automatic wait_toggle(output int n);
        logic b;
        @(negedge sys_clk);
        b = bit_clk_pos_ff;
        for (n = 1; n <= 20; n++) begin
            @(posedge sys_clk);
            #1;
            if (bit_clk_pos_ff !== b)
                return;
        end
        give_up();
    endtask

    task automatic t_stream(input out_fmt_e f, input int n);
        @(posedge sys_clk);
        format_sel <= f;
        for (int i = 0; i < 200 && format_ff !== f; i++)
            @(negedge sys_clk);
        chk_val(56'(format_ff), 56'(f));
        @(posedge sys_clk);
        push(56'hffffffffffffff);
        for (int i = 0; i < n; i++)
            push(word(i));
        sample_valid <= 1'b0;
        drain();
    endtask

    task automatic t_fill();
        int i;
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        for (i = 0; i < 16; i++) begin
            sample_data <= word(i + 40);
            @(negedge sys_clk);
            if (sample_ready !== 1'b1)
                break;
            exp_q.push_back(word(i + 40));
            @(posedge sys_clk);
        end
        chk_val(56'(sample_ready), 56'h0);
        push(word(i + 40));
        sample_valid <= 1'b0;
        drain();
        for (i = 0; i < 60 && underrun_ff !== 1'b1; i++)
            @(negedge sys_clk);
        chk_val(56'(underrun_ff), 56'h1);
    endtask

    task automatic t_div();
        div_mode_e m[3] = '{DIV_BYPASS, DIV_BY2, DIV_BY4};
        int g[3] = '{1, 2, 4};
        int n;
        foreach (m[k]) begin
            @(posedge sys_clk);
            div_sel <= m[k];
            repeat (80) @(posedge sys_clk);
            wait_toggle(n);
            wait_toggle(n);
            chk_val(56'(n), 56'(g[k]));
        end
    endtask

    // divide-by-4 assumed; one-shot sync right after a bit step
    task automatic t_sync(input logic pdn);
        int n;
        @(posedge sys_clk);
        sync_buffer_powerdown <= pdn;
        push(word(90));
        sample_valid <= 1'b0;
        wait_toggle(n);
        @(posedge sys_clk);
        sync_reference_pos <= 1'b1;
        sync_reference_neg <= 1'b0;
        repeat (2) @(posedge sys_clk);
        sync_reference_pos <= 1'b0;
        sync_reference_neg <= 1'b1;
        #1;
        if (!pdn)
            chk_val(56'(div_clk_ff), 56'h0);
        wait_toggle(n);
        chk_val(56'(n > 1), 56'(!pdn));
        drain();
    endtask

    task automatic t_periodic();
        @(posedge sys_clk);
        push(word(91));
        sample_valid <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            sync_reference_pos <= 1'b1;
            sync_reference_neg <= 1'b0;
            repeat (2) @(posedge sys_clk);
            sync_reference_pos <= 1'b0;
            sync_reference_neg <= 1'b1;
            #1;
            chk_val(56'(div_clk_ff), 56'h0);
            repeat (5) @(posedge sys_clk);
        end
        drain();
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        chk_val(56'(format_ff), 56'(FMT_TWO_WIRE));
        arst_n <= 1'b1;
        t_stream(FMT_TWO_WIRE, 6);
        t_stream(FMT_ONE_WIRE, 6);
        t_fill();
        t_stream(FMT_TWO_WIRE, 3);
        t_div();
        t_sync(1'b1);
        t_sync(1'b0);
        t_periodic();
        repeat (60) @(posedge sys_clk);
        chk_val(56'(err_cnt), 56'h0);
        tally_and_finish();
    end

    initial begin
        #300000;
        give_up();
    end
endmodule
